// [hdl/sfd_top.sv]
// starter fault response, acknowledgement and parameter echo
//
// How it works
// RULE1 - master gets an echo by writing the parameter to the starter
// RULE2 - master job byte 0 is write parameter command 02
// RULE3 - master job byte 1 is the starter slave address
// RULE4 - master job byte 2: upper nibble zero, parameter bits below
// RULE5 - response byte holds echo code in bits 3..0, zeros above
// RULE6 - master always sends all four parameter bits
// RULE7 - alarm faults set group alarm, flash indicator, motor keeps running
// RULE8 - shutdown faults set group fault, steady lamps, motor and brake off
// RULE9 - mapping errors and device faults always shut down
// RULE10 - after shutdown stay off until fault gone and acknowledged
// RULE11 - both direction commands together acknowledge a trip
// RULE12 - key switch in O position acknowledges a trip
// RULE13 - autoreset option acknowledges faults without outside action
// RULE14 - opposite command acknowledges mapping errors only
// RULE15 - trip reset acts on the edge, once per held condition
// RULE16 - fault select bit picks fault codes or warning codes
// RULE17 - echo shows one top priority item until it clears
// RULE18 - parameter bits 1, 2 and bank switch bit are ignored
// RULE19 - acknowledge in the cycle the both commands condition appears; trip_ack here rises one cycle after it at the synchronised pins
`timescale 1ns/1ps
`include "sfd_defines.svh"
module sfd_top #(
   parameter bit HAS_KEY = 1'b1
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // parameter channel
   input wire logic param_wr_valid,
   input wire logic [3:0] param_wr_value,
   output logic echo_valid,
   output logic [7:0] echo_byte,
   // fault and message sources, one bit per code
   input wire logic [15:0] fault_act,
   input wire logic [15:0] msg_act,
   input wire logic proc_map_err,
   // configuration
   input wire logic [15:0] cfg_shutdown,
   input wire logic cfg_autoreset,
   // command pins
   input wire logic motor_cw_command,
   input wire logic motor_ccw_command,
   input wire logic key_switch_off,
   // status and indicators
   output logic group_alarm,
   output logic group_fault,
   output logic device_led_flash,
   output logic device_led_steady,
   output logic system_fault_indicator,
   // contact blocks
   output logic motor_cw_drive,
   output logic motor_ccw_drive,
   output logic brake_release
);
   sfd_pkg::sfd_top_st_t st;
   sfd_pkg::sfd_top_st_t next_st;
   logic [15:0] sd_mask;
   logic shut_now;
   logic alarm_now;
   logic ack_any;
   logic pme_ack;
   logic halted;

   sfd_if lk ();

   ////////////////////////////////////////////////////////////////
   // parts

   sfd_echo_sel u_echo (
      .ref_clk (ref_clk),
      .rst (rst),
      .lk (lk.echo)
   );

   sfd_ack_det u_ack (
      .ref_clk (ref_clk),
      .rst (rst),
      .lk (lk.ack)
   );

   ////////////////////////////////////////////////////////////////
   // interface feed: only the fault select bit steers the echo
   assign lk.fault_act = fault_act;
   assign lk.msg_act = msg_act;
   assign lk.req = param_wr_valid; // RULE1
   assign lk.sel = param_wr_value[`SFD_FSEL_BIT]; // RULE16 RULE18
   assign lk.cw = st.sync2[0];
   assign lk.ccw = st.sync2[1];
   assign lk.key_o = st.sync2[2] & HAS_KEY;

   ////////////////////////////////////////////////////////////////
   // fault classification and acknowledge sources
   always_comb begin
      sd_mask = cfg_shutdown | `SFD_FORCED_SD; // RULE9
      shut_now = |(fault_act & `SFD_FLT_VALID & sd_mask); // RULE8
      alarm_now = |(fault_act & `SFD_FLT_VALID & ~sd_mask); // RULE7
      ack_any = lk.trip_ack | cfg_autoreset; // RULE11 RULE12 RULE13
      pme_ack = ack_any | lk.off_ack; // RULE14
      halted = st.shut | st.pme;
   end

   ////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      next_st = st;
      // two stage synchronisers for the command pins
      next_st.sync1 = {key_switch_off, motor_ccw_command, motor_cw_command};
      next_st.sync2 = st.sync1;
      // shutdown latch: a present cause always wins over the acknowledge
      next_st.shut = shut_now | (st.shut & ~ack_any); // RULE8 RULE10
      // mapping error latch, always a shutdown
      next_st.pme = proc_map_err | (st.pme & ~pme_ack); // RULE9 RULE14
      // status and indicators
      next_st.group_fault = next_st.shut | next_st.pme; // RULE8
      next_st.group_alarm = alarm_now; // RULE7
      next_st.led_steady = next_st.group_fault; // RULE8
      next_st.sf_led = next_st.group_fault; // RULE8
      next_st.led_flash = alarm_now & ~next_st.group_fault; // RULE7
      // contact blocks: both commands is a reset request, never a run
      next_st.cw_drive = st.sync2[0] & ~st.sync2[1] & ~next_st.group_fault; // RULE7 RULE10
      next_st.ccw_drive = st.sync2[1] & ~st.sync2[0] & ~next_st.group_fault; // RULE7 RULE10
      next_st.brake = next_st.cw_drive | next_st.ccw_drive; // RULE8
      // echo answer
      next_st.echo_valid = lk.echo_valid;
      if (lk.echo_valid) begin
         next_st.echo_byte = {`SFD_ECHO_UPPER, lk.echo_code}; // RULE5
      end
   end

   // state register
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////
   // outputs
   assign echo_valid = st.echo_valid;
   assign echo_byte = st.echo_byte;
   assign group_alarm = st.group_alarm;
   assign group_fault = st.group_fault;
   assign device_led_flash = st.led_flash;
   assign device_led_steady = st.led_steady;
   assign system_fault_indicator = st.sf_led;
   assign motor_cw_drive = st.cw_drive;
   assign motor_ccw_drive = st.ccw_drive;
   assign brake_release = st.brake;

   ////////////////////////////////////////////////////////////////
   // checks
   AST_ECHO_BYTE: assert property (@(posedge ref_clk) disable iff (rst) // RULE5
      param_wr_valid |-> ##2 echo_valid && echo_byte[7:4] == `SFD_ECHO_UPPER)
      else $error("echo missing or upper bits set");
   AST_SHUT_OFF: assert property (@(posedge ref_clk) disable iff (rst) // RULE8
      shut_now |=> group_fault && system_fault_indicator && device_led_steady
      && !motor_cw_drive && !motor_ccw_drive && !brake_release)
      else $error("shutdown fault left motor running");
   AST_ALARM_ONLY: assert property (@(posedge ref_clk) disable iff (rst) // RULE7
      alarm_now && !shut_now && !halted && !proc_map_err
      && st.sync2 == 3'h1 && !ack_any |=> group_alarm && device_led_flash
      && motor_cw_drive && brake_release)
      else $error("alarm fault stopped motor");
   AST_FORCED: assert property (@(posedge ref_clk) disable iff (rst) // RULE9
      |(fault_act & `SFD_FORCED_SD) || proc_map_err |=> group_fault)
      else $error("forced fault did not shut down");
   AST_NEEDS_ACK: assert property (@(posedge ref_clk) disable iff (rst) // RULE10
      st.shut ##1 !st.shut |-> $past(ack_any) && !$past(shut_now))
      else $error("restart without acknowledge");
   AST_AUTORESET: assert property (@(posedge ref_clk) disable iff (rst) // RULE13
      cfg_autoreset && st.shut && !shut_now |=> !st.shut)
      else $error("autoreset did not clear");
   AST_IGNORE_BITS: assert property (@(posedge ref_clk) disable iff (rst) // RULE18
      param_wr_valid |-> ##2 echo_byte[3:0] == ($past(param_wr_value[`SFD_FSEL_BIT], 2)
      ? $past(u_echo.st.held_flt, 2) : $past(u_echo.st.held_msg, 2)))
      else $error("ignored parameter bits steer echo");
   CVR_SHUTDOWN: cover property (@(posedge ref_clk) disable iff (rst)
      $fell(group_fault));
   CVR_ALARM: cover property (@(posedge ref_clk) disable iff (rst)
      device_led_flash && motor_cw_drive);
   CVR_PME_OFF: cover property (@(posedge ref_clk) disable iff (rst)
      st.pme && lk.off_ack && !proc_map_err);
endmodule : sfd_top

// [shared/sfd_defines.svh]
// constants of the starter fault, acknowledgement and echo logic
`ifndef SFD_DEFINES_SVH
`define SFD_DEFINES_SVH

// echo byte layout
`define SFD_ECHO_W 4
`define SFD_ECHO_UPPER 4'h0
`define SFD_CODE_NONE 4'h0
// parameter bit that picks faults (1) or warnings and messages (0)
`define SFD_FSEL_BIT 0
// priorities by code, code 15 in the top byte, 8'h10 is the lowest
`define SFD_FLT_PRIO 128'h0B_04_09_06_10_02_05_10_10_03_01_08_0A_07_10_10
`define SFD_MSG_PRIO 128'h10_10_10_0A_07_08_10_10_10_10_10_09_10_10_10_10
`define SFD_PRIO_NONE 8'h10
// codes that exist
`define SFD_FLT_VALID 16'hF67C
`define SFD_MSG_VALID 16'h1C10
// faults that always shut down (device error)
`define SFD_FORCED_SD 16'h0020

`endif

// [shared/sfd_pkg.sv]
// state types of the starter fault, acknowledgement and echo logic
package sfd_pkg;

   // echo selector state
   typedef struct packed {
      logic [3:0] held_flt;
      logic [3:0] held_msg;
      logic [3:0] code;
      logic valid;
   } sfd_echo_st_t;

   // trip reset edge detector state
   typedef struct packed {
      logic both_prev;
      logic key_prev;
      logic on_prev;
      logic trip_ack;
      logic off_ack;
   } sfd_ack_st_t;

   // top level state
   typedef struct packed {
      logic [2:0] sync1;
      logic [2:0] sync2;
      logic shut;
      logic pme;
      logic group_alarm;
      logic group_fault;
      logic led_flash;
      logic led_steady;
      logic sf_led;
      logic cw_drive;
      logic ccw_drive;
      logic brake;
      logic echo_valid;
      logic [7:0] echo_byte;
   } sfd_top_st_t;

endpackage : sfd_pkg

// [shared/sfd_if.sv]
// links between the starter top and its echo and acknowledgement parts
`timescale 1ns/1ps
interface sfd_if;
   logic [15:0] fault_act;
   logic [15:0] msg_act;
   logic req;
   logic sel;
   logic [3:0] echo_code;
   logic echo_valid;
   logic cw;
   logic ccw;
   logic key_o;
   logic trip_ack;
   logic off_ack;

   modport top (
      output fault_act, msg_act, req, sel, cw, ccw, key_o,
      input echo_code, echo_valid, trip_ack, off_ack
   );
   modport echo (
      input fault_act, msg_act, req, sel,
      output echo_code, echo_valid
   );
   modport ack (
      input cw, ccw, key_o,
      output trip_ack, off_ack
   );
endinterface : sfd_if

// [hdl/sfd_ack_det.sv]
// trip reset and opposite command edge detector
`timescale 1ns/1ps
`include "sfd_defines.svh"
module sfd_ack_det (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // link to top
   sfd_if.ack lk
);
   sfd_pkg::sfd_ack_st_t st;
   sfd_pkg::sfd_ack_st_t next_st;
   logic both;
   logic on;

   // one pulse per rising edge of a reset condition
   always_comb begin
      both = lk.cw & lk.ccw;
      on = lk.cw | lk.ccw;
      next_st = st;
      next_st.both_prev = both;
      next_st.key_prev = lk.key_o;
      next_st.on_prev = on;
      next_st.trip_ack = (both & ~st.both_prev) | (lk.key_o & ~st.key_prev); // RULE11 RULE12 RULE15 RULE19
      next_st.off_ack = ~on & st.on_prev; // RULE14
   end

   // state register
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign lk.trip_ack = st.trip_ack;
   assign lk.off_ack = st.off_ack;

   ////////////////////////////////////////////////////////////////
   AST_BOTH_ACK: assert property (@(posedge ref_clk) disable iff (rst) // RULE19
      $rose(lk.cw & lk.ccw) |=> lk.trip_ack)
      else $error("both commands did not acknowledge");
   AST_ONE_SHOT: assert property (@(posedge ref_clk) disable iff (rst) // RULE15
      lk.trip_ack && $past(lk.cw & lk.ccw) && (lk.cw & lk.ccw)
      && $stable(lk.key_o) |=> !lk.trip_ack)
      else $error("held trip reset acknowledged twice");
   AST_KEY_ACK: assert property (@(posedge ref_clk) disable iff (rst) // RULE12
      $rose(lk.key_o) |=> lk.trip_ack)
      else $error("key switch did not acknowledge");
   CVR_TRIP: cover property (@(posedge ref_clk) disable iff (rst) lk.trip_ack);
endmodule : sfd_ack_det

// [hdl/sfd_echo_sel.sv]
// parameter echo selector holding the top priority item
`timescale 1ns/1ps
`include "sfd_defines.svh"
module sfd_echo_sel (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // link to top
   sfd_if.echo lk
);
   sfd_pkg::sfd_echo_st_t st;
   sfd_pkg::sfd_echo_st_t next_st;

   // code of the active item with the best priority, none if idle
   function automatic logic [3:0] best(input logic [15:0] act, input logic [127:0] tab);
      logic [3:0] c;
      logic [7:0] p;
      c = `SFD_CODE_NONE;
      p = `SFD_PRIO_NONE;
      for (int i = 0; i < 16; i++) begin
         if (act[i] && tab[i*8 +: 8] < p) begin
            p = tab[i*8 +: 8];
            c = 4'(i);
         end
      end
      return c;
   endfunction : best

   // keep the held item until it clears, then pick again
   always_comb begin
      next_st = st;
      if (st.held_flt == `SFD_CODE_NONE || !lk.fault_act[st.held_flt]) begin // RULE17
         next_st.held_flt = best(lk.fault_act & `SFD_FLT_VALID, `SFD_FLT_PRIO);
      end
      if (st.held_msg == `SFD_CODE_NONE || !lk.msg_act[st.held_msg]) begin // RULE17
         next_st.held_msg = best(lk.msg_act & `SFD_MSG_VALID, `SFD_MSG_PRIO);
      end
      next_st.valid = lk.req;
      if (lk.req) begin
         next_st.code = lk.sel ? st.held_flt : st.held_msg; // RULE16
      end
   end

   // state register
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign lk.echo_code = st.code;
   assign lk.echo_valid = st.valid;

   ////////////////////////////////////////////////////////////////
   AST_SEL_FLT: assert property (@(posedge ref_clk) disable iff (rst) // RULE16
      lk.req && lk.sel |=> lk.echo_valid && lk.echo_code == $past(st.held_flt))
      else $error("fault echo not returned");
   AST_SEL_MSG: assert property (@(posedge ref_clk) disable iff (rst) // RULE16
      lk.req && !lk.sel |=> lk.echo_valid && lk.echo_code == $past(st.held_msg))
      else $error("message echo not returned");
   AST_HOLD_ITEM: assert property (@(posedge ref_clk) disable iff (rst) // RULE17
      st.held_flt != `SFD_CODE_NONE && lk.fault_act[st.held_flt] |=> $stable(st.held_flt))
      else $error("held fault replaced while present");
   CVR_FLT_ECHO: cover property (@(posedge ref_clk) disable iff (rst)
      lk.req && lk.sel && st.held_flt != `SFD_CODE_NONE);
endmodule : sfd_echo_sel

// [tb/sfd_master_model.sv]
// network master model that issues write-parameter jobs and collects the echo
`timescale 1ns/1ps
module sfd_master_model #(
   parameter logic [7:0] SLAVE_ADDR = 8'h01
) (
   // clock
   input wire logic ref_clk,
   // parameter channel toward the starter
   output logic param_wr_valid,
   output logic [3:0] param_wr_value,
   input wire logic echo_valid,
   input wire logic [7:0] echo_byte
);
   localparam logic [7:0] CMD_WRITE_PARAM = 8'h02;

   initial begin
      param_wr_valid = 1'b0;
      param_wr_value = 4'h0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // one write-parameter job, answer taken as the response to it
   task automatic write_param(input logic [3:0] bits, output logic [7:0] echo,
                              output int lat);
      logic [7:0] job [0:2];
      job[0] = CMD_WRITE_PARAM;
      job[1] = SLAVE_ADDR;
      job[2] = {4'h0, bits};
      // cycles counted from the request cycle, the release being the first
      lat = 1;
      echo = 8'hFF;
      @(negedge ref_clk);
      param_wr_valid = 1'b1;
      param_wr_value = job[2][3:0];
      @(posedge ref_clk);
      @(negedge ref_clk);
      param_wr_valid = 1'b0;
      param_wr_value = ~job[2][3:0]; // released value must not look still valid
      while (echo_valid !== 1'b1 && lat < 8) begin
         @(negedge ref_clk);
         lat++;
      end
      echo = echo_byte;
   endtask : write_param
endmodule : sfd_master_model

// [tb/sfd_top_tb_top.sv]
// self-checking bench of the starter fault, acknowledgement and echo logic
`timescale 1ns/1ps
`define CHK(what, exp, got) begin \
   comparisons++; \
   if ((got) !== (exp)) begin \
      n_errors++; \
      $display("BAD %s expected %h seen %h", what, exp, got); \
   end \
end
module sfd_top_tb_top;
   logic ref_clk, rst, param_wr_valid, echo_valid, proc_map_err, cfg_autoreset;
   logic motor_cw_command, motor_ccw_command, key_switch_off;
   logic group_alarm, group_fault, device_led_flash, device_led_steady;
   logic system_fault_indicator, motor_cw_drive, motor_ccw_drive, brake_release;
   logic [3:0] param_wr_value;
   logic [7:0] echo_byte;
   logic [15:0] fault_act, msg_act, cfg_shutdown;
   logic [4:0] st;
   logic [2:0] drv;
   int n_errors = 0;
   int comparisons = 0;

   // status and drive views: alarm, fault, flash, steady, system fault
   assign st = {group_alarm, group_fault, device_led_flash, device_led_steady,
                system_fault_indicator};
   assign drv = {motor_cw_drive, motor_ccw_drive, brake_release};

   ////////////////////////////////////////////////////////////////////////////
   // design and far-side master
   sfd_top #(.HAS_KEY(1'b1)) u_sfd_top (
      .ref_clk(ref_clk), .rst(rst), .param_wr_valid(param_wr_valid),
      .param_wr_value(param_wr_value), .echo_valid(echo_valid), .echo_byte(echo_byte),
      .fault_act(fault_act), .msg_act(msg_act), .proc_map_err(proc_map_err),
      .cfg_shutdown(cfg_shutdown), .cfg_autoreset(cfg_autoreset),
      .motor_cw_command(motor_cw_command), .motor_ccw_command(motor_ccw_command),
      .key_switch_off(key_switch_off), .group_alarm(group_alarm),
      .group_fault(group_fault), .device_led_flash(device_led_flash),
      .device_led_steady(device_led_steady),
      .system_fault_indicator(system_fault_indicator),
      .motor_cw_drive(motor_cw_drive), .motor_ccw_drive(motor_ccw_drive),
      .brake_release(brake_release)
   );
   sfd_master_model u_sfd_master_model (
      .ref_clk(ref_clk), .param_wr_valid(param_wr_valid),
      .param_wr_value(param_wr_value), .echo_valid(echo_valid), .echo_byte(echo_byte)
   );

   ////////////////////////////////////////////////////////////////////////////
   // clock and watchdog
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (3000) @(posedge ref_clk);
      n_errors++;
      $display("BAD watchdog expected end seen hang");
      wrap_up();
   end

   // helpers
   task automatic wt(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : wt
   task automatic echo_chk(input logic [3:0] bits, input logic [7:0] exp);
      logic [7:0] e;
      int lat;
      u_sfd_master_model.write_param(bits, e, lat);
      `CHK("echo byte", exp, e)
      `CHK("echo latency", 2, lat)
   endtask : echo_chk
   task automatic done(input string name);
      $display("test %s done", name);
   endtask : done
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : wrap_up

   ////////////////////////////////////////////////////////////////////////////
   // test sequence
   initial begin
      rst = 1'b1;
      {proc_map_err, cfg_autoreset, motor_cw_command, motor_ccw_command} = 4'h0;
      key_switch_off = 1'b0;
      fault_act = 16'h0000;
      msg_act = 16'h0000;
      cfg_shutdown = 16'h0000;
      wt(4);
      rst = 1'b0;
      `CHK("reset status", 5'h00, st)
      `CHK("reset drives", 3'h0, drv)
      done("reset");
      // echo selection and priority hold
      fault_act = 16'h2200;
      msg_act = 16'h1800;
      wt(3);
      echo_chk(4'h0, 8'h0B);
      echo_chk(4'hE, 8'h0B);
      echo_chk(4'h1, 8'h09);
      echo_chk(4'hF, 8'h09);
      fault_act = 16'h2220;
      wt(3);
      echo_chk(4'h1, 8'h09);
      `CHK("forced shutdown", 5'h1B, st)
      fault_act = 16'h0020;
      msg_act = 16'h0000;
      wt(3);
      echo_chk(4'h1, 8'h05);
      echo_chk(4'h0, 8'h00);
      fault_act = 16'h0000;
      wt(3);
      echo_chk(4'h1, 8'h00);
      key_switch_off = 1'b1;
      wt(6);
      `CHK("key ack", 5'h00, st)
      key_switch_off = 1'b0;
      done("echo");
      // alarm response keeps the motor, shutdown response stops it
      cfg_shutdown = 16'h0004;
      motor_cw_command = 1'b1;
      wt(5);
      fault_act = 16'h2000;
      wt(3);
      `CHK("alarm status", 5'h14, st)
      `CHK("alarm drives", 3'h5, drv)
      fault_act = 16'h2004;
      wt(3);
      `CHK("shutdown status", 5'h1B, st)
      `CHK("shutdown drives", 3'h0, drv)
      fault_act = 16'h0004;
      motor_ccw_command = 1'b1;
      wt(6);
      `CHK("ack under cause", 5'h0B, st)
      `CHK("both cmds drive", 3'h0, drv)
      fault_act = 16'h0000;
      wt(6);
      `CHK("held trip reset", 5'h0B, st)
      motor_ccw_command = 1'b0;
      wt(6);
      motor_ccw_command = 1'b1;
      wt(6);
      `CHK("trip reset edge", 5'h00, st)
      motor_ccw_command = 1'b0;
      done("response");
      // mapping error, opposite command acknowledges
      wt(5);
      proc_map_err = 1'b1;
      wt(4);
      `CHK("mapping shutdown", 5'h0B, st)
      proc_map_err = 1'b0;
      wt(6);
      `CHK("mapping held", 5'h0B, st)
      motor_cw_command = 1'b0;
      wt(6);
      `CHK("opposite ack", 5'h00, st)
      done("mapping");
      // autoreset
      cfg_autoreset = 1'b1;
      fault_act = 16'h0004;
      wt(3);
      `CHK("auto shutdown", 5'h0B, st)
      fault_act = 16'h0000;
      wt(3);
      `CHK("auto ack", 5'h00, st)
      motor_ccw_command = 1'b1;
      wt(4);
      `CHK("ccw drives", 3'h3, drv)
      motor_ccw_command = 1'b0;
      done("autoreset");
      wrap_up();
   end
endmodule : sfd_top_tb_top
